/* rtl/ccs_defines.vh */
// Functional notes
// - clkout runs at full, half or quarter system rate per cfg bits 1:0
// - after reset the divider selects quarter rate
// - divider value 3 stops the output clock entirely
// - clock reaches the pin only while its mux selects clock-out function
// - one select bit picks the clock input pin; reset picks the jtag pin
// - with the external path dropped, internal oscillators may clock the device
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH

// register byte offsets
`define CCS_ADDR_CFG 8'h00
`define CCS_ADDR_CTL 8'h04
`define CCS_ADDR_MUX 8'h08
`define CCS_ADDR_STAT 8'h0C

// configuration register fields
`define CCS_DIV_MSB 1
`define CCS_DIV_LSB 0
`define CCS_PINSEL_BIT 6

// control register fields
`define CCS_SRC_EXT_BIT 0
`define CCS_EXT_OFF_BIT 13
`define CCS_XTAL_OFF_BIT 14

// pin mux field and the clock-out function code
`define CCS_MUX_MSB 1
`define CCS_MUX_LSB 0
`define CCS_FUNC_CLKOUT 2'h1

// divider codes
`define CCS_DIV_QUARTER 2'h0
`define CCS_DIV_HALF 2'h1
`define CCS_DIV_FULL 2'h2
`define CCS_DIV_OFF 2'h3

// input pin select codes
`define CCS_PIN_JTAG 1'h0
`define CCS_PIN_ALT 1'h1

// active clock source codes
`define CCS_SRC_INTERNAL 2'h0
`define CCS_SRC_EXTERNAL 2'h1
`define CCS_SRC_CRYSTAL 2'h2

// reset values
`define CCS_DIV_RST 2'h0
`define CCS_PINSEL_RST 1'h0
`define CCS_MUX_RST 2'h0

// status register fields
`define CCS_STAT_EXT_BIT 0
`define CCS_STAT_XTAL_BIT 1
`define CCS_STAT_DBG_BIT 2
`define CCS_STAT_SRC_LSB 4
`define CCS_STAT_DIV_LSB 8

// ahb codes
`define CCS_HSIZE_WORD 3'h2

`endif

/* rtl/ccs_sync.v */
`timescale 1ns/100ps
// two-stage synchroniser; the first stage feeds only the second
module ccs_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    // metastability guard before any logic looks at the pins
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* rtl/ccs_clk_div.v */
`timescale 1ns/100ps
`include "ccs_defines.vh"
// clock-out divider; a new setting takes effect only at the end of a
// quarter-rate period so the output never shows a runt pulse
module ccs_clk_div (
    input wire clock,
    input wire rst_n,
    input wire [1:0] div_sel,
    output wire clk_out,
    output reg [1:0] active_sel
);
    reg [1:0] cnt;
    reg slow;
    reg fast_p;
    reg fast_n;
    wire [1:0] next_cnt;

    assign next_cnt = cnt + 2'h1;

    // free-running phase counter and settings latch
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 2'h0;
            active_sel <= `CCS_DIV_RST;
            slow <= 1'b0;
            fast_p <= 1'b0;
        end else begin
            cnt <= next_cnt;
            if (cnt == 2'h3) begin
                active_sel <= div_sel;
            end
            case (active_sel)
                `CCS_DIV_QUARTER: slow <= next_cnt[1];
                `CCS_DIV_HALF: slow <= next_cnt[0];
                default: slow <= 1'b0;
            endcase
            if (active_sel == `CCS_DIV_FULL) begin
                fast_p <= ~fast_p;
            end
        end
    end

    // falling-edge follower: the xor gives a full-rate copy of the clock
    always @(negedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fast_n <= 1'b0;
        end else begin
            fast_n <= fast_p;
        end
    end

    // full rate cannot come from one flop, so it is rebuilt from two
    assign clk_out = (active_sel == `CCS_DIV_FULL) ? (fast_p ^ fast_n) : slow;
endmodule

/* rtl/ccs_top.v */
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "ccs_defines.vh"
// clock-out and clock-source select block with an ahb-lite register slave
module ccs_top (
    input wire clock,
    input wire rst_n,
    // ahb-lite register slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // candidate clock pins and board status, all asynchronous to this clock
    input wire jtag_shared_clkin_pin,
    input wire alt_clkin_pin,
    input wire crystal_in,
    input wire debug_attached,
    // clock pin drive and the source report
    output wire clkout_pin_out,
    output reg clkout_pin_oe,
    output reg ext_clock_in,
    output reg crystal_clock_in,
    output reg [1:0] clk_src_sel
);
    // reset release pair
    reg rst_meta;
    reg rst_sync_n;

    // software-visible control fields
    reg [1:0] clkout_div_sel;
    reg ext_clock_pin_sel;
    reg src_ext;
    reg ext_path_off;
    reg xtal_off;
    reg [1:0] pin_func;

    // write held from its address phase into its data phase
    reg wr_pending;
    reg [7:0] wr_addr;

    // values the control fields take at the next edge
    reg [1:0] next_div_sel;
    reg next_pin_sel;
    reg next_src_ext;
    reg next_ext_off;
    reg next_xtal_off;
    reg [1:0] next_pin_func;

    // source choice and the links to the helpers
    reg [1:0] next_src;
    reg debug_blocks_ext;
    wire [3:0] pins_sync;
    wire div_clk;
    wire [1:0] div_active;
    wire addr_take;

    // release reset through two flops; assertion stays asynchronous
    // a release close to an edge must not reach the flops in different cycles
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // every pin that enters this domain is synchronised first
    ccs_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clock(clock),
        .rst_n(rst_sync_n),
        .d({debug_attached, crystal_in, alt_clkin_pin, jtag_shared_clkin_pin}),
        .q(pins_sync)
    );

    ccs_clk_div u_div (
        .clock(clock),
        .rst_n(rst_sync_n),
        .div_sel(clkout_div_sel),
        .clk_out(div_clk),
        .active_sel(div_active)
    );

    // level of whichever candidate pin the select bit names; the status image
    // and the external path share it so they can never disagree on the choice
    function pin_pick;
        input sel;
        input [1:0] pins;
        begin
            pin_pick = (sel == `CCS_PIN_ALT) ? pins[1] : pins[0];
        end
    endfunction

    // read image of one register; shared by the read path for every offset
    function [31:0] reg_image;
        input [7:0] addr;
        input [1:0] div_f;
        input pin_sel_f;
        input src_ext_f;
        input ext_off_f;
        input xtal_off_f;
        input [1:0] func_f;
        input [3:0] pins_f;
        input [1:0] src_f;
        input [1:0] div_act_f;
        reg [31:0] img;
        begin
            img = 32'h00000000;
            case (addr)
                `CCS_ADDR_CFG: begin
                    img[`CCS_DIV_MSB:`CCS_DIV_LSB] = div_f;
                    img[`CCS_PINSEL_BIT] = pin_sel_f;
                end
                `CCS_ADDR_CTL: begin
                    img[`CCS_SRC_EXT_BIT] = src_ext_f;
                    img[`CCS_EXT_OFF_BIT] = ext_off_f;
                    img[`CCS_XTAL_OFF_BIT] = xtal_off_f;
                end
                `CCS_ADDR_MUX: begin
                    img[`CCS_MUX_MSB:`CCS_MUX_LSB] = func_f;
                end
                `CCS_ADDR_STAT: begin
                    img[`CCS_STAT_EXT_BIT] = pin_pick(pin_sel_f, pins_f[1:0]);
                    img[`CCS_STAT_XTAL_BIT] = pins_f[2];
                    img[`CCS_STAT_DBG_BIT] = pins_f[3];
                    img[`CCS_STAT_SRC_LSB+1:`CCS_STAT_SRC_LSB] = src_f;
                    img[`CCS_STAT_DIV_LSB+1:`CCS_STAT_DIV_LSB] = div_act_f;
                end
                default: begin
                    img = 32'h00000000; // unmapped offsets read as zero
                end
            endcase
            reg_image = img;
        end
    endfunction

    // an address phase is taken only when the bus is ready and the slave is picked
    assign addr_take = hsel & hready & htrans[1];

    // values the registers hold after this cycle's data-phase write
    always @* begin
        next_div_sel = clkout_div_sel;
        next_pin_sel = ext_clock_pin_sel;
        next_src_ext = src_ext;
        next_ext_off = ext_path_off;
        next_xtal_off = xtal_off;
        next_pin_func = pin_func;
        if (wr_pending) begin
            case (wr_addr)
                `CCS_ADDR_CFG: begin
                    next_div_sel = hwdata[`CCS_DIV_MSB:`CCS_DIV_LSB];
                    next_pin_sel = hwdata[`CCS_PINSEL_BIT];
                end
                `CCS_ADDR_CTL: begin
                    next_src_ext = hwdata[`CCS_SRC_EXT_BIT];
                    next_ext_off = hwdata[`CCS_EXT_OFF_BIT];
                    next_xtal_off = hwdata[`CCS_XTAL_OFF_BIT];
                end
                `CCS_ADDR_MUX: begin
                    next_pin_func = hwdata[`CCS_MUX_MSB:`CCS_MUX_LSB];
                end
                default: begin
                    next_pin_func = pin_func; // status and unmapped ignore writes
                end
            endcase
        end
    end

    // a debugger on the shared jtag pin makes that pin unusable as a clock;
    // the path is dropped in hardware so software cannot forget to do it
    always @* begin
        debug_blocks_ext = pins_sync[3] & (ext_clock_pin_sel == `CCS_PIN_JTAG);
    end

    // clock source choice; internal oscillator is the fallback
    // whenever both outside sources are off or blocked
    always @* begin
        if (!src_ext) begin
            next_src = `CCS_SRC_INTERNAL;
        end else if (!ext_path_off && !debug_blocks_ext) begin
            next_src = `CCS_SRC_EXTERNAL;
        end else if (!xtal_off) begin
            next_src = `CCS_SRC_CRYSTAL;
        end else begin
            next_src = `CCS_SRC_INTERNAL;
        end
    end

    // bus handshake: zero wait states and always an okay response; ready
    // stays low through reset so no transfer is taken half initialised
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // a write's address phase is kept for the data phase, where hwdata stands;
    // narrow writes are dropped here so no field is ever half written
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pending <= addr_take & hwrite & (hsize == `CCS_HSIZE_WORD);
            if (addr_take) begin
                wr_addr <= haddr[7:0];
            end
        end
    end

    // read data is loaded at the address edge and stands until the next read;
    // it is built from the next values so a read right behind a write sees it
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hrdata <= 32'h00000000;
        end else if (addr_take && !hwrite) begin
            hrdata <= reg_image(haddr[7:0], next_div_sel, next_pin_sel, next_src_ext,
                next_ext_off, next_xtal_off, next_pin_func, pins_sync, clk_src_sel,
                div_active);
        end
    end

    // configuration field: divider and input pin select; the divider itself
    // waits for its own period boundary, so a write here never cuts a pulse
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clkout_div_sel <= `CCS_DIV_RST;
            ext_clock_pin_sel <= `CCS_PINSEL_RST;
        end else begin
            clkout_div_sel <= next_div_sel;
            ext_clock_pin_sel <= next_pin_sel;
        end
    end

    // control field: source use and the two path disables; both paths run
    // after reset so either kind of board clock is seen before software acts
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            src_ext <= 1'b0;
            ext_path_off <= 1'b0;
            xtal_off <= 1'b0;
        end else begin
            src_ext <= next_src_ext;
            ext_path_off <= next_ext_off;
            xtal_off <= next_xtal_off;
        end
    end

    // pin function field; the pin stays undriven until software picks clock-out
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_func <= `CCS_MUX_RST;
        end else begin
            pin_func <= next_pin_func;
        end
    end

    // external clock path; held low while disabled or blocked by a debugger,
    // so a test clock on the shared pin never reaches the clock tree
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_clock_in <= 1'b0;
        end else if (ext_path_off || debug_blocks_ext) begin
            ext_clock_in <= 1'b0;
        end else begin
            ext_clock_in <= pin_pick(ext_clock_pin_sel, pins_sync[1:0]);
        end
    end

    // crystal path; a disabled oscillator reads as a steady low rather than
    // whatever noise the grounded input pin picks up
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            crystal_clock_in <= 1'b0;
        end else begin
            crystal_clock_in <= xtal_off ? 1'b0 : pins_sync[2];
        end
    end

    // active source report and pin enable; both lag their fields by one
    // cycle, which keeps every output of the block except clkout_pin_out on a flop
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clk_src_sel <= `CCS_SRC_INTERNAL;
            clkout_pin_oe <= 1'b0;
        end else begin
            clk_src_sel <= next_src;
            clkout_pin_oe <= (pin_func == `CCS_FUNC_CLKOUT);
        end
    end

    // the pin sees the divided clock only with the clock-out function selected;
    // a clock cannot be re-registered here without halving it again
    assign clkout_pin_out = clkout_pin_oe & div_clk;
endmodule

/* tb/ccs_top_checker.sv */
`timescale 1ns/100ps
// watches the pins against a shadow of the registers, snooped off the bus
module ccs_checker (
    input wire clock,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hresp,
    input wire jtag_shared_clkin_pin,
    input wire alt_clkin_pin,
    input wire crystal_in,
    input wire debug_attached,
    input wire clkout_pin_out,
    input wire clkout_pin_oe,
    input wire ext_clock_in,
    input wire crystal_clock_in,
    input wire [1:0] clk_src_sel
);
    logic wv, ps, out_n;
    logic [7:0] wa;
    logic [1:0] dv, mx;
    logic [14:0] ct;
    logic [3:0] stab;
    logic [4:0] dh;
    // calm: long enough since the last write for every lag to have run out
    wire calm = stab == 4'hF;
    // shadow registers; dh keeps the recent debug history for the sync lag
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {wv, wa, dv, mx, ps, ct, stab, dh} <= '0;
        end else begin
            wv <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
            wa <= haddr[7:0];
            dh <= {dh[3:0], debug_attached};
            stab <= wv ? 4'h0 : stab + {3'h0, stab != 4'hF};
            if (wv && wa == 8'h00) {ps, dv} <= {hwdata[6], hwdata[1:0]};
            if (wv && wa == 8'h04) ct <= hwdata[14:0];
            if (wv && wa == 8'h08) mx <= hwdata[1:0];
        end
    end
    // level just before the falling edge, read before the design's updates land
    always @(negedge clock) out_n <= clkout_pin_out;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_QUARTER: assert property (calm && dv == 2'h0 && clkout_pin_oe && $past(clkout_pin_oe, 2)
        |-> clkout_pin_out != $past(clkout_pin_out, 2)) else $error("quarter rate wrong");
    AST_HALF: assert property (calm && dv == 2'h1 && clkout_pin_oe && $past(clkout_pin_oe)
        |-> clkout_pin_out != $past(clkout_pin_out)) else $error("half rate wrong");
    AST_FULL: assert property (calm && dv == 2'h2 && clkout_pin_oe && $past(clkout_pin_oe)
        |-> clkout_pin_out != out_n) else $error("full rate wrong");
    AST_OFF: assert property (calm && dv == 2'h3 |-> !clkout_pin_out)
        else $error("clock out not stopped");
    AST_GATE: assert property (!clkout_pin_oe |-> !clkout_pin_out)
        else $error("clock on pin without mux");
    AST_MUX: assert property (calm |-> clkout_pin_oe == (mx == 2'h1))
        else $error("pin enable does not follow mux");
    AST_ALT: assert property (calm && ps && !ct[13]
        |-> ext_clock_in == $past(alt_clkin_pin, 3)) else $error("alt pin not followed");
    AST_JTAG: assert property (calm && !ps && !ct[13] && dh == 5'h00
        |-> ext_clock_in == $past(jtag_shared_clkin_pin, 3)) else $error("jtag pin not followed");
    AST_DEBUG: assert property (calm && !ps && dh == 5'h1F
        |-> !ext_clock_in && clk_src_sel != 2'h1) else $error("debug does not block path");
    AST_SRC: assert property (calm && ct[0] && ct[14] && (ct[13] || dh == 5'h1F && !ps)
        |-> clk_src_sel == 2'h0) else $error("internal source not chosen");
    AST_XTAL: assert property (calm && !ct[14]
        |-> crystal_clock_in == $past(crystal_in, 3)) else $error("crystal not followed");
    AST_XOFF: assert property (calm && ct[14] |-> !crystal_clock_in)
        else $error("crystal path not stopped");
    AST_OKAY: assert property (!hresp)
        else $error("bus response not okay");
endmodule
bind ccs_top ccs_checker u_chk (.*);

/* tb/ccs_osc_model.sv */
`timescale 1ns/100ps
// board side: oscillator, second clock pin, crystal and the debugger's test clock
module ccs_osc_model (
    input wire logic dbg,
    output wire logic pin_a,
    output logic pin_b,
    output logic xtal
);
    logic osc = 1'b0;
    logic tck = 1'b0;
    initial {pin_b, xtal} = 2'h0;
    // unrelated half periods, all shifted by half a nanosecond: the system
    // clock only moves on whole nanoseconds, so no free-running toggle lands on its edge
    initial begin
        #0.5;
        fork
            forever #17 osc = !osc;
            forever #23 pin_b = !pin_b;
            forever #29 xtal = !xtal;
            forever #7 tck = !tck;
        join
    end
    // an attached debugger drives its test clock onto the shared pin
    assign pin_a = dbg ? tck : osc;
endmodule

/* tb/tb_clock_out_and_source_select.sv */
`timescale 1ns/100ps
module tb_clock_out_and_source_select;
    logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, dbg = 1'b0, p;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, v, w;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire hready, hreadyout, hresp, oe, out, eci, xci, pa, pb, px;
    wire [31:0] hrdata;
    wire [1:0] src;
    integer errors = 0, total_checks = 0, cyc = 0, ecnt = 0, i;
    integer seed = 32'hBBC582A2;
    assign hready = hreadyout;
    always #10 clock = ~clock;
    always @(posedge out) ecnt = ecnt + 1;
    ccs_osc_model PM (.dbg(dbg), .pin_a(pa), .pin_b(pb), .xtal(px));
    ccs_top DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .jtag_shared_clkin_pin(pa),
        .alt_clkin_pin(pb), .crystal_in(px), .debug_attached(dbg), .clkout_pin_out(out),
        .clkout_pin_oe(oe), .ext_clock_in(eci), .crystal_clock_in(xci), .clk_src_sel(src));
    task stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // a hang is cut short well past the longest run of the sequence
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            stop_test;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; address held until hready, then the data phase
    task xfer(input [7:0] a, input wr, input [31:0] d, input [2:0] sz);
        @(posedge clock);
        {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, wr, sz, 24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task measure(input [31:0] exp);
        repeat (10) @(posedge clock);
        @(negedge clock) ecnt = 0;
        repeat (64) @(negedge clock);
        chk(ecnt, exp);
    endtask
    function [31:0] exp_edges(input [1:0] d);
        exp_edges = d == 2'h0 ? 16 : d == 2'h1 ? 32 : d == 2'h2 ? 64 : 0;
    endfunction
    function [1:0] exp_src(input [31:0] c, input ps, input g);
        if (!c[0]) exp_src = 2'h0;
        else if (!c[13] && !(g && !ps)) exp_src = 2'h1;
        else exp_src = c[14] ? 2'h0 : 2'h2;
    endfunction
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge clock);
        xfer(8'h00, 0, 0, 3'h2);
        chk(rd, 32'h0);
        xfer(8'h0C, 0, 0, 3'h2);
        chk({28'h0, rd[9:8], rd[5:4]}, 32'h0);
        xfer(8'h10, 0, 0, 3'h2);
        chk(rd, 32'h0);
        measure(0);
        xfer(8'h08, 1, 32'h1, 3'h2);
        // every code once, then random codes
        for (i = 0; i < 10; i++) begin
            v = i < 4 ? i : $random(seed) & 32'h3;
            xfer(8'h00, 1, v, 3'h2);
            measure(exp_edges(v[1:0]));
            xfer(8'h0C, 0, 0, 3'h2);
            chk({30'h0, rd[9:8]}, v);
        end
        xfer(8'h00, 1, 32'h2, 3'h1);
        xfer(8'h00, 0, 0, 3'h2);
        chk(rd, v);
        xfer(8'h08, 1, 32'h2, 3'h2);
        xfer(8'h00, 1, 32'h0, 3'h2);
        measure(0);
        // all control settings against both debug states, pin choice at random
        for (i = 0; i < 16; i++) begin
            v = $random(seed);
            p = v[0];
            w = {17'h0, i[2], i[1], 12'h0, i[0]};
            xfer(8'h04, 1, w, 3'h2);
            xfer(8'h00, 1, {25'h0, p, 6'h0}, 3'h2);
            @(posedge clock) dbg <= i[3];
            repeat (20) @(posedge clock);
            chk({30'h0, src}, {30'h0, exp_src(w, p, i[3])});
        end
        @(posedge clock) rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge clock);
        chk({31'h0, oe}, 32'h0);
        xfer(8'h00, 0, 0, 3'h2);
        chk(rd, 32'h0);
        stop_test;
    end
endmodule
